// ===== hdl/pafm_port_a_mux.sv
/*
  Port A alternate function multiplexer with register port, two timers
  and the per-pin output selection.
  Assumes synchronous pin inputs, a 10 MHz core clock, a board pull-up on
  strobe pins, and external memory/FIFO/serial sources as plain inputs.
*/
// Chosen here: the plain strobed port and the register addresses.
// What this block does
// R1: Pin 0 is a port bit when its first-pulse select is 0 and shows timer one overflow when 1.
// R2: Timer one's overflow output is high for exactly one clock per overflow.
// R3: In split mode timer one's pulse comes from the low-byte counter wrapping.
// R4: Pin 1 is a port bit when its second-pulse select is 0 and shows timer two overflow when 1.
// R5: Timer two's overflow output is high for exactly one clock per overflow.
// R6: In split mode timer two's pulse comes from the low-byte counter wrapping.
// R7: Pin 2 drives the active-low memory output enable when its select is 1.
// R8: Pin 3 drives the active-low memory chip select when its select is 1.
// R9: Pin 4 drives the active-low FIFO write strobe when its select is 1.
// R10: Pin 5 drives the active-low FIFO read strobe when its select is 1.
// R11: Pin 6 is a port bit by default and carries serial one output when selected.
// R12: Selected pin 6 carries serial one data only in sync mode 0, else holds 1.
// R13: Pin 7 is a port bit by default and carries serial two output when selected.
// R14: Selected pin 7 carries serial two data in mode 0 and holds 1 in modes 1 to 3.
// R15: The board pulls memory and FIFO strobe pins up so they idle high at power-on.
// R16: After reset all select bits read 0 and every pin is a port input.
// R17: An alternate output function drives its pin whatever the port direction bit says.
`timescale 1ns/1ps
module pafm_port_a_mux #(
  parameter int PINS        = 8,
  parameter int TIMER_WIDTH = 16
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            reset_n_in,
  // Register port
  input  wire logic [3:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  input  wire logic            reg_write_in,
  input  wire logic            reg_read_in,
  output logic      [7:0]      reg_rdata_out,
  // Alternate function sources
  input  wire logic            mem_output_enable_n_in,
  input  wire logic            mem_chip_select_n_in,
  input  wire logic            fifo_write_strobe_n_in,
  input  wire logic            fifo_read_strobe_n_in,
  input  wire logic            first_serial_data_in,
  input  wire logic            second_serial_data_in,
  // Port A pins
  input  wire logic [PINS-1:0] port_a_pin_in,
  output logic      [PINS-1:0] port_a_pin_out,
  output logic      [PINS-1:0] port_a_pin_oe_out,
  // Timer pulses for other logic
  output logic                 first_timer_pulse_out,
  output logic                 second_timer_pulse_out
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]       port_a_function_config;
  logic [PINS-1:0]  port_out;
  logic [PINS-1:0]  port_dir;
  logic [7:0]       timer_ctrl;
  logic [7:0]       serial_cfg;
  logic [7:0]       next_rdata;

  logic             wr_func;
  logic             wr_out;
  logic             wr_dir;
  logic             wr_tctl;
  logic             wr_scfg;

  assign wr_func = reg_write_in && (reg_addr_in == pafm_pkg::ADDR_FUNC_CFG);
  assign wr_out  = reg_write_in && (reg_addr_in == pafm_pkg::ADDR_PORT_OUT);
  assign wr_dir  = reg_write_in && (reg_addr_in == pafm_pkg::ADDR_PORT_DIR);
  assign wr_tctl = reg_write_in && (reg_addr_in == pafm_pkg::ADDR_TIMER_CTRL);
  assign wr_scfg = reg_write_in && (reg_addr_in == pafm_pkg::ADDR_SERIAL_CFG);

  // Selects clear to 0 so every pin starts as a port input, see R16
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_a_function_config <= pafm_pkg::RST_FUNC_CFG;
      port_out               <= pafm_pkg::RST_PORT_OUT[PINS-1:0];
      port_dir               <= pafm_pkg::RST_PORT_DIR[PINS-1:0];
      timer_ctrl             <= pafm_pkg::RST_BYTE;
      serial_cfg             <= pafm_pkg::RST_BYTE;
    end else begin
      if (wr_func) port_a_function_config <= reg_wdata_in;
      if (wr_out)  port_out <= reg_wdata_in[PINS-1:0];
      if (wr_dir)  port_dir <= reg_wdata_in[PINS-1:0];
      if (wr_tctl) timer_ctrl <= reg_wdata_in;
      if (wr_scfg) serial_cfg <= reg_wdata_in;
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  logic [TIMER_WIDTH-1:0] count0;
  logic [TIMER_WIDTH-1:0] count1;
  logic [1:0]             tmode0;
  logic [1:0]             tmode1;

  assign tmode0 = timer_ctrl[pafm_pkg::TCTL_MODE0 +: 2];
  assign tmode1 = timer_ctrl[pafm_pkg::TCTL_MODE1 +: 2];

  pafm_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_first_timer (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .run_in        (timer_ctrl[pafm_pkg::TCTL_RUN0]),
    .mode_in       (tmode0),
    .ovf_pulse_out (first_timer_pulse_out),
    .count_out     (count0)
  );

  pafm_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_second_timer (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .run_in        (timer_ctrl[pafm_pkg::TCTL_RUN1]),
    .mode_in       (tmode1),
    .ovf_pulse_out (second_timer_pulse_out),
    .count_out     (count1)
  );

  // ****************************************
  // Serial pin values
  // ****************************************
  logic first_serial_level;
  logic second_serial_level;
  logic first_sync;
  logic second_sync;

  assign first_sync  = serial_cfg[pafm_pkg::SCFG_MODE0 +: 2] == pafm_pkg::SERIAL_MODE_SYNC;
  assign second_sync = serial_cfg[pafm_pkg::SCFG_MODE1 +: 2] == pafm_pkg::SERIAL_MODE_SYNC;
  // Idle high outside sync mode, see R12 see R14
  assign first_serial_level  = first_sync  ? first_serial_data_in  : 1'b1;
  assign second_serial_level = second_sync ? second_serial_data_in : 1'b1;

  // ****************************************
  // Per-pin selection
  // ****************************************
  logic [PINS-1:0] alt_value;
  logic [PINS-1:0] alt_sel;
  logic [PINS-1:0] next_pin_out;
  logic [PINS-1:0] next_pin_oe;

  assign alt_value = {second_serial_level,      // see R13
                      first_serial_level,       // see R11
                      fifo_read_strobe_n_in,    // see R10
                      fifo_write_strobe_n_in,   // see R9
                      mem_chip_select_n_in,     // see R8
                      mem_output_enable_n_in,   // see R7
                      second_timer_pulse_out,   // see R4
                      first_timer_pulse_out};   // see R1
  assign alt_sel = port_a_function_config[PINS-1:0];

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // Alternate function overrides direction, see R17
      assign next_pin_out[g] = alt_sel[g] ? alt_value[g] : port_out[g];
      assign next_pin_oe[g]  = alt_sel[g] | port_dir[g];
    end
  endgenerate

  // Pins are combinational so the one-clock timer pulse is not delayed.
  assign port_a_pin_out    = next_pin_out;
  assign port_a_pin_oe_out = next_pin_oe;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] status_byte;

  assign status_byte = {6'h00, second_timer_pulse_out, first_timer_pulse_out};

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_in)
      pafm_pkg::ADDR_FUNC_CFG:   next_rdata = port_a_function_config;
      pafm_pkg::ADDR_PORT_OUT:   next_rdata = 8'(port_out);
      pafm_pkg::ADDR_PORT_DIR:   next_rdata = 8'(port_dir);
      pafm_pkg::ADDR_PORT_PINS:  next_rdata = 8'(port_a_pin_in);
      pafm_pkg::ADDR_TIMER_CTRL: next_rdata = timer_ctrl;
      pafm_pkg::ADDR_SERIAL_CFG: next_rdata = serial_cfg;
      pafm_pkg::ADDR_STATUS:     next_rdata = status_byte;
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= pafm_pkg::RST_BYTE;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= pafm_pkg::RST_BYTE;
    end
  end

  // Unused in logic: counts kept for visibility of timer state.
  logic unused_counts;
  assign unused_counts = ^{count0, count1};

endmodule

// ===== hdl/pafm_pkg.sv
/*
  Package for the port A function multiplexer: register offsets, field
  positions, reset values and mode codes.
  Assumes a plain strobe register port on a single core clock.
*/
package pafm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_FUNC_CFG   = 4'h0;
  localparam logic [3:0] ADDR_PORT_OUT   = 4'h1;
  localparam logic [3:0] ADDR_PORT_DIR   = 4'h2;
  localparam logic [3:0] ADDR_PORT_PINS  = 4'h3;
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SERIAL_CFG = 4'h5;
  localparam logic [3:0] ADDR_STATUS     = 4'h6;

  // ****************************************
  // Function select field positions
  // ****************************************
  localparam int SEL_FIRST_PULSE  = 0;
  localparam int SEL_SECOND_PULSE = 1;
  localparam int SEL_MEM_ENABLE   = 2;
  localparam int SEL_MEM_SELECT   = 3;
  localparam int SEL_FAST_WRITE   = 4;
  localparam int SEL_FAST_READ    = 5;
  localparam int SEL_FIRST_SERIAL = 6;
  localparam int SEL_SECOND_SER   = 7;

  // ****************************************
  // Timer control fields
  // ****************************************
  localparam int TCTL_RUN0  = 0;
  localparam int TCTL_MODE0 = 1;
  localparam int TCTL_RUN1  = 4;
  localparam int TCTL_MODE1 = 5;

  // ****************************************
  // Serial config fields
  // ****************************************
  localparam int SCFG_MODE0 = 0;
  localparam int SCFG_MODE1 = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_FUNC_CFG = 8'h00;
  localparam logic [7:0] RST_PORT_OUT = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [1:0] TIMER_MODE_SPLIT = 2'h3;
  localparam logic [1:0] TIMER_MODE_8RELD = 2'h2;
  localparam logic [1:0] SERIAL_MODE_SYNC = 2'h0;

endpackage

// ===== hdl/pafm_timer.sv
/*
  One timer with a one-cycle overflow pulse.
  Assumes a 16-bit counter ticking every core clock while running.
*/
`timescale 1ns/1ps
module pafm_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [1:0] mode_in,
  // Pulse and count
  output logic            ovf_pulse_out,
  output logic [WIDTH-1:0] count_out
);

  localparam int HALF = WIDTH / 2;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             low_wrap;
  logic             full_wrap;
  logic             split_mode;
  logic             reload_mode;
  logic             next_pulse;

  // ****************************************
  // Count and wrap detection
  // ****************************************
  assign split_mode  = (mode_in == pafm_pkg::TIMER_MODE_SPLIT);
  assign reload_mode = (mode_in == pafm_pkg::TIMER_MODE_8RELD);
  assign low_wrap    = run_in && (&count[HALF-1:0]);
  assign full_wrap   = run_in && (&count);
  // Split mode: low byte alone decides the overflow, see R3 see R6
  assign next_pulse  = (split_mode || reload_mode) ? low_wrap : full_wrap;
  assign next_count  = !run_in ? count :
                       (split_mode || reload_mode) ?
                         {count[WIDTH-1:HALF],
                          (reload_mode && low_wrap) ? count[WIDTH-1:HALF]
                                                    : count[HALF-1:0] + 1'b1} :
                         count + 1'b1;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count         <= '0;
      ovf_pulse_out <= 1'b0;
    end else begin
      count         <= next_count;
      ovf_pulse_out <= next_pulse; // One clock high per wrap, see R2 see R5
    end
  end

  assign count_out = count;

endmodule

// ===== verif/pafm_port_a_mux_properties.sv
/*
  Checker for the port A function mux, bound to every instance.
  Assumes one clock domain and the register map of the package.
*/
`timescale 1ns/1ps
module pafm_port_a_mux_properties #(
  parameter int PINS        = 8,
  parameter int TIMER_WIDTH = 16
) (
  // Clock, reset, register port
  input wire logic            clk_in,
  input wire logic            reset_n_in,
  input wire logic [3:0]      reg_addr_in,
  input wire logic [7:0]      reg_wdata_in,
  input wire logic            reg_write_in,
  input wire logic            reg_read_in,
  input wire logic [7:0]      reg_rdata_out,
  // Function sources
  input wire logic            mem_output_enable_n_in,
  input wire logic            mem_chip_select_n_in,
  input wire logic            fifo_write_strobe_n_in,
  input wire logic            fifo_read_strobe_n_in,
  input wire logic            first_serial_data_in,
  input wire logic            second_serial_data_in,
  // Pins and pulses
  input wire logic [PINS-1:0] port_a_pin_in,
  input wire logic [PINS-1:0] port_a_pin_out,
  input wire logic [PINS-1:0] port_a_pin_oe_out,
  input wire logic            first_timer_pulse_out,
  input wire logic            second_timer_pulse_out
);
  // ****
  // Shadow registers
  // ****
  logic [7:0] regs [0:15];
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 16; i++) regs[i] <= 8'h00;
    end else if (reg_write_in) begin
      regs[reg_addr_in] <= reg_wdata_in;
    end
  end
  wire logic [7:0] cfg  = regs[pafm_pkg::ADDR_FUNC_CFG];
  wire logic [7:0] pout = regs[pafm_pkg::ADDR_PORT_OUT];
  wire logic [7:0] pdir = regs[pafm_pkg::ADDR_PORT_DIR];
  wire logic [7:0] scfg = regs[pafm_pkg::ADDR_SERIAL_CFG];
  wire logic [7:0] po   = port_a_pin_out[7:0];
  wire logic [7:0] oe   = port_a_pin_oe_out[7:0];
  wire logic [3:0] strb = {fifo_read_strobe_n_in, fifo_write_strobe_n_in,
                           mem_chip_select_n_in, mem_output_enable_n_in};
  wire logic       s1   = (scfg[1:0] == 2'h0) ? first_serial_data_in : 1'b1;
  wire logic       s2   = (scfg[3:2] == 2'h0) ? second_serial_data_in : 1'b1;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_first_drop;
    ##1 !first_timer_pulse_out;
  endsequence
  sequence s_second_drop;
    ##1 !second_timer_pulse_out;
  endsequence
  sequence s_cfg_read;
    reg_read_in && reg_addr_in == pafm_pkg::ADDR_FUNC_CFG;
  endsequence
  a_pin_zero_pulse: assert property (cfg[0] |-> oe[0] && po[0] == first_timer_pulse_out)
    else $error("pin 0 lost first pulse");
  a_pin_one_pulse: assert property (cfg[1] |-> oe[1] && po[1] == second_timer_pulse_out)
    else $error("pin 1 lost second pulse");
  a_first_pulse_width: assert property (first_timer_pulse_out |-> s_first_drop)
    else $error("first pulse too long");
  a_second_pulse_width: assert property (second_timer_pulse_out |-> s_second_drop)
    else $error("second pulse too long");
  a_strobe_pass: assert property ((po[5:2] & cfg[5:2]) == (strb & cfg[5:2]))
    else $error("strobe pin mismatch");
  a_serial_one_out: assert property (cfg[6] |-> po[6] == s1)
    else $error("pin 6 serial mismatch");
  a_serial_two_out: assert property (cfg[7] |-> po[7] == s2)
    else $error("pin 7 serial mismatch");
  a_port_bit_follow: assert property ((((po ^ pout) | (oe ^ pdir)) & ~cfg) == 8'h00)
    else $error("port bit mismatch");
  a_alt_drives: assert property ((oe & cfg) == cfg)
    else $error("alternate pin not driven");
  a_reset_clean: assert property ($rose(reset_n_in) |-> oe == 8'h00 && reg_rdata_out == 8'h00)
    else $error("pins driven after reset");
  a_cfg_readback: assert property (s_cfg_read |=> reg_rdata_out == $past(cfg))
    else $error("select readback mismatch");
endmodule

bind pafm_port_a_mux pafm_port_a_mux_properties #(.PINS(PINS), .TIMER_WIDTH(TIMER_WIDTH)) chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .mem_output_enable_n_in(mem_output_enable_n_in),
  .mem_chip_select_n_in(mem_chip_select_n_in), .fifo_write_strobe_n_in(fifo_write_strobe_n_in),
  .fifo_read_strobe_n_in(fifo_read_strobe_n_in), .first_serial_data_in(first_serial_data_in),
  .second_serial_data_in(second_serial_data_in), .port_a_pin_in(port_a_pin_in),
  .port_a_pin_out(port_a_pin_out), .port_a_pin_oe_out(port_a_pin_oe_out),
  .first_timer_pulse_out(first_timer_pulse_out),
  .second_timer_pulse_out(second_timer_pulse_out));

// ===== verif/pafm_board_model.sv
/*
  Board model for port A: resolves each pin from the mux and the board.
  Assumes board pull-ups on the memory and FIFO strobe pins.
*/
`timescale 1ns/1ps
module pafm_board_model (
  // Mux side
  input  wire logic [7:0] pin_drive_in,
  input  wire logic [7:0] pin_oe_in,
  // Board drivers
  input  wire logic [7:0] ext_drive_in,
  input  wire logic [7:0] ext_oe_in,
  output logic      [7:0] pin_level_out
);
  // Floating pins other than the pulled-up pins 2 to 5 flip so a stale level never passes for a driven one
  initial pin_level_out = 8'h00;
  always @(pin_drive_in or pin_oe_in or ext_drive_in or ext_oe_in) begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_in[i]) begin
        pin_level_out[i] = pin_drive_in[i];
      end else if (ext_oe_in[i]) begin
        pin_level_out[i] = ext_drive_in[i];
      end else if (i >= 2 && i <= 5) begin
        pin_level_out[i] = 1'b1;
      end else begin
        pin_level_out[i] = ~pin_level_out[i];
      end
    end
  end
endmodule

// ===== verif/test_port_a_alternate_function_mux.sv
/*
  Self-checking bench for the port A function mux.
  Assumes the board model and the bound checker sit alongside.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module test_port_a_alternate_function_mux;
  logic       clk_in     = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       we         = 1'b0;
  logic       re         = 1'b0;
  logic [3:0] strobes    = 4'hF;
  logic [1:0] ser        = 2'h0;
  logic [7:0] ext_val    = 8'h00;
  logic [7:0] ext_oe     = 8'h00;
  logic [7:0] rdata, pin_out, pin_oe, pin_lvl;
  logic       pulse1, pulse2;
  int         failures   = 0;
  int         n_checks   = 0;
  localparam logic [3:0] AD [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
  always #50 clk_in = ~clk_in;
  pafm_port_a_mux dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata),
    .mem_output_enable_n_in(strobes[0]), .mem_chip_select_n_in(strobes[1]),
    .fifo_write_strobe_n_in(strobes[2]), .fifo_read_strobe_n_in(strobes[3]),
    .first_serial_data_in(ser[0]), .second_serial_data_in(ser[1]),
    .port_a_pin_in(pin_lvl), .port_a_pin_out(pin_out), .port_a_pin_oe_out(pin_oe),
    .first_timer_pulse_out(pulse1), .second_timer_pulse_out(pulse2));
  pafm_board_model board (.pin_drive_in(pin_out), .pin_oe_in(pin_oe),
    .ext_drive_in(ext_val), .ext_oe_in(ext_oe), .pin_level_out(pin_lvl));
  // ****
  // Access tasks
  // ****
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_in);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_in);
    re <= 1'b0;
    @(negedge clk_in);
    `CHK(rdata, e)
  endtask
  task automatic pins(input logic [7:0] o, input logic [7:0] e);
    @(negedge clk_in);
    `CHK(pin_out, o)
    `CHK(pin_oe, e)
  endtask
  task automatic gap(input bit second, output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((second ? pulse2 : pulse1) !== 1'b1 && n < 600);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    int n;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    pins(8'h00, 8'h00);
    foreach (AD[i]) rd(AD[i], 8'h00);
    wr(pafm_pkg::ADDR_PORT_DIR, 8'hFF);
    wr(pafm_pkg::ADDR_PORT_OUT, 8'hA5);
    pins(8'hA5, 8'hFF);
    wr(pafm_pkg::ADDR_PORT_DIR, 8'h00);
    ext_oe <= 8'hFF;
    ext_val <= 8'h5A;
    repeat (3) @(posedge clk_in);
    rd(pafm_pkg::ADDR_PORT_PINS, 8'h5A);
    @(posedge clk_in);
    ext_oe <= 8'h00;
    wr(pafm_pkg::ADDR_FUNC_CFG, 8'h3C);
    rd(pafm_pkg::ADDR_FUNC_CFG, 8'h3C);
    for (int p = 0; p < 16; p += 5) begin
      @(posedge clk_in);
      strobes <= p[3:0];
      pins(8'h81 | {2'b00, p[3:0], 2'b00}, 8'h3C);
    end
    wr(pafm_pkg::ADDR_FUNC_CFG, 8'hC0);
    for (int m = 0; m < 4; m++) begin
      wr(pafm_pkg::ADDR_SERIAL_CFG, {4'h0, m[1:0], m[1:0]});
      for (int d = 0; d < 2; d++) begin
        @(posedge clk_in);
        ser <= {d[0], d[0]};
        pins({(m == 0) ? {d[0], d[0]} : 2'b11, 6'h25}, 8'hC0);
      end
    end
    wr(pafm_pkg::ADDR_FUNC_CFG, 8'h03);
    wr(pafm_pkg::ADDR_TIMER_CTRL, 8'h77);
    for (int t = 0; t < 2; t++) begin
      gap(t[0], n);
      gap(t[0], n);
      `CHK(n, 256)
      `CHK(pin_out[t], 1'b1)
    end
    // Reload mode: high byte still 0, so the low byte wraps every 256 clocks
    wr(pafm_pkg::ADDR_TIMER_CTRL, 8'h55);
    gap(1'b0, n);
    gap(1'b0, n);
    `CHK(n, 256)
    // Full 16-bit mode: a low-byte wrap alone must not pulse
    wr(pafm_pkg::ADDR_TIMER_CTRL, 8'h11);
    gap(1'b1, n);
    `CHK(n, 600)
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(pafm_pkg::ADDR_FUNC_CFG, 8'h00);
    pins(8'h00, 8'h00);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    failures++;
    summarize();
  end
endmodule
